// ==== bench/interrupt_vector_priority_map_bench.sv ====
// Self-checking bench for the interrupt vector resolver
`timescale 1ns/10ps
module interrupt_vector_priority_map_bench;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [28:0] src_pat = 29'h0;
    reg mon_stb = 1'b0;
    reg [2:0] mask = 3'h0;
    wire [9:0] off;
    logic [1:0] rsp;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [1:0] avs_response;
    wire nmi, slp, wdt, adc, ve, dok, bok, der, ber;
    wire [11:0] ext;
    wire [4:0] t0;
    wire [3:0] t1, t2, lv;
    wire [7:0] vec;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [13:0] exp_q[$];
    logic [31:0] rd;
    logic [31:0] rng = 32'h70468AC0;
    logic [28:0] m;
    int w;

    ivpm_src_model i_src (.clk(clk), .pattern(src_pat), .nmi_pin_request(nmi), .sleep_request(slp),
        .external_request(ext), .watchdog_overflow_request(wdt), .conversion_end_request(adc),
        .timer0_request(t0), .timer1_request(t1), .timer2_request(t2));
    ivpm_top i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .nmi_pin_request(nmi),
        .external_request(ext), .sleep_request(slp), .watchdog_overflow_request(wdt),
        .conversion_end_request(adc), .timer0_request(t0), .timer1_request(t1), .timer2_request(t2),
        .cpu_mask_level(mask), .irq_valid_q(ve), .irq_vector_q(vec), .irq_offset_q(off), .irq_level_q(lv),
        .data_transfer_engine_ok_q(dok), .block_move_engine_ok_q(bok), .data_transfer_engine_error_q(der),
        .block_move_engine_error_q(ber), .block_move_engine_stop_q());

    always #50 clk = ~clk;

    // -------------------------------
    // Helpers
    // -------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Avalon-MM cycle held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Expected {dte, bme, vector} of a source index
    function automatic logic [9:0] map(input int i);
        logic [7:0] v;
        v = i == 0 ? 8'h07 : i == 1 ? 8'h12 : i < 14 ? 8'h3E + i : i == 14 ? 8'h51 : i == 15 ? 8'h56 : 8'h48 + i;
        return {(i >= 2 && i <= 13) || i == 15 || (i >= 16 && i <= 19) || i == 21 || i == 22 || i == 25 || i == 26,
            i == 15 || i == 16 || i == 21 || i == 25, v};
    endfunction

    // Note the expectation, wait for the vector, then strobe the monitor
    task expect_src(input int i, input logic [3:0] lvl);
        logic [9:0] e;
        int k;
        e = map(i);
        k = 0;
        exp_q.push_back({lvl, e});
        while (k < 10 && !(ve === 1'b1 && vec === e[7:0])) begin
            @(posedge clk);
            k++;
        end
        mon_stb <= 1'b1;
        @(posedge clk);
        mon_stb <= 1'b0;
    endtask

    task srcs(input logic [28:0] p);
        @(posedge clk);
        src_pat <= p;
    endtask

    // Monitor compares the oldest note with the outputs
    always @(posedge clk) begin
        if (mon_stb) begin
            chk({8'h0, off, lv, dok, bok, vec}, {8'h0, exp_q[0][7:0], 2'b00, exp_q[0]});
            exp_q.delete(0);
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    // -------------------------------
    // Main sequence
    // -------------------------------
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        bus(0, 8'h1C, 0);
        chk(rd, 32'h0);
        bus(0, 8'h14, 0);
        chk(rd, 32'h7777);
        bus(0, 8'hFC, 0);
        chk({rsp, rd[29:0]}, 32'h80000000);
        for (int i = 1; i < 29; i++) begin
            srcs(29'h1 << i);
            expect_src(i, i == 1 ? 4'h8 : 4'h0);
            srcs(0);
            repeat (6) @(posedge clk);
        end
        repeat (12) begin
            rng = xs(rng);
            m = rng[28:0] & ~29'h1;
            w = 28;
            for (int j = 28; j > 0; j--) if (m[j]) w = j;
            srcs(m);
            expect_src(w, w == 1 ? 4'h8 : 4'h0);
            srcs(0);
            repeat (6) @(posedge clk);
        end
        bus(1, 8'h14, 32'h0107);
        srcs((29'h1 << 15) | (29'h1 << 21));
        expect_src(15, 4'h0);
        bus(1, 8'h1C, 32'h2);
        expect_src(21, 4'h7);
        bus(1, 8'h14, 32'h0707);
        expect_src(15, 4'h7);
        mask <= 3'h7;
        srcs(29'h1 | (29'h1 << 16));
        expect_src(0, 4'h8);
        chk({der, ber}, 2'b11);
        repeat (2) @(posedge clk);
        chk({31'h0, ve}, 32'h0);
        wrap_up;
    end
endmodule // interrupt_vector_priority_map_bench

// ==== bench/ivpm_src_model.sv ====
// Peripheral and pin source model driving the resolver
`timescale 1ns/10ps
module ivpm_src_model (
    // Clock
    input wire clk,
    // Pattern in source index order
    input wire [28:0] pattern,
    // Source lines
    output reg nmi_pin_request = 1'b0,
    output reg sleep_request = 1'b0,
    output reg [11:0] external_request = 12'h000,
    output reg watchdog_overflow_request = 1'b0,
    output reg conversion_end_request = 1'b0,
    output reg [4:0] timer0_request = 5'h00,
    output reg [3:0] timer1_request = 4'h0,
    output reg [3:0] timer2_request = 4'h0
);
    // Sources change just after an edge, like on-chip flops
    always @(posedge clk) begin
        {timer2_request, timer1_request, timer0_request, conversion_end_request, watchdog_overflow_request,
            external_request, sleep_request, nmi_pin_request} <= pattern;
    end
endmodule // ivpm_src_model

// ==== bench/ivpm_top_asserts.sv ====
// Concurrent checks on the resolved request outputs
`timescale 1ns/10ps
module ivpm_checker (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Resolved request
    input wire irq_valid_q,
    input wire [7:0] irq_vector_q,
    input wire [9:0] irq_offset_q,
    input wire [3:0] irq_level_q,
    input wire data_transfer_engine_ok_q,
    input wire block_move_engine_ok_q,
    // Error effects
    input wire data_transfer_engine_error_q,
    input wire block_move_engine_error_q,
    input wire block_move_engine_stop_q
);
    wire v = irq_valid_q;
    wire [7:0] n = irq_vector_q;
    wire dte = data_transfer_engine_ok_q;
    wire bme = block_move_engine_ok_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Stop is a single-cycle pulse
    sequence s_stop_pulse;
        block_move_engine_stop_q ##1 !block_move_engine_stop_q;
    endsequence
    a_offset_times_four: assert property (v |-> irq_offset_q == {n, 2'b00}) else $error("offset mismatch");
    a_no_reserved: assert property (v |-> !((n >= 76 && n <= 80) || (n >= 82 && n <= 85) || n == 87))
        else $error("reserved vector issued");
    a_nmi_top: assert property (v && n == 7 |-> irq_level_q == 4'h8 && !dte && !bme) else $error("nmi map");
    a_sleep_map: assert property (v && n == 18 |-> irq_level_q == 4'h8 && !dte && !bme) else $error("sleep map");
    a_ext_engines: assert property (v && n >= 64 && n <= 75 |-> dte && !bme) else $error("ext engines");
    a_wdt_engines: assert property (v && n == 81 |-> !dte && !bme) else $error("wdt engines");
    a_adc_engines: assert property (v && n == 86 |-> dte && bme) else $error("adc engines");
    a_t0_engines: assert property (v && n >= 88 && n <= 92 |-> dte == (n != 92) && bme == (n == 88))
        else $error("timer0 engines");
    a_t12_engines: assert property (v && n >= 93 && n <= 100 |-> dte == (n == 93 || n == 94 || n == 97 || n == 98)
        && bme == (n == 93 || n == 97)) else $error("timer1/2 engines");
    a_stop_pulse: assert property ($rose(block_move_engine_stop_q) |-> s_stop_pulse) else $error("stop width");
    a_nmi_errors: assert property (block_move_engine_stop_q |-> ##[0:1] (data_transfer_engine_error_q
        && block_move_engine_error_q)) else $error("nmi errors missing");
endmodule // ivpm_checker
bind ivpm_top ivpm_checker u_chk (.clk(clk), .sys_rst(sys_rst), .irq_valid_q(irq_valid_q),
    .irq_vector_q(irq_vector_q), .irq_offset_q(irq_offset_q), .irq_level_q(irq_level_q),
    .data_transfer_engine_ok_q(data_transfer_engine_ok_q), .block_move_engine_ok_q(block_move_engine_ok_q),
    .data_transfer_engine_error_q(data_transfer_engine_error_q),
    .block_move_engine_error_q(block_move_engine_error_q), .block_move_engine_stop_q(block_move_engine_stop_q));

// ==== design/ivpm_arbiter.v ====
// Combinational priority arbiter over all sources
`timescale 1ns/10ps
`include "ivpm_defs.vh"

module ivpm_arbiter #(
    parameter NSRC = `IVPM_NSRC
) (
    // Requests and their effective levels, four bits per source
    input wire [NSRC-1:0] req,
    input wire [4*NSRC-1:0] lvl,
    // Winner
    output reg any,
    output reg [4:0] win
);

// -----------------------------------------------------------------
// Selection
// -----------------------------------------------------------------
integer i;
reg [3:0] best;

// Walk from highest index down so ties go to the lower vector
always @* begin
    any = 1'b0;
    win = 5'h00;
    best = 4'h0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (req[i] && (!any || lvl[4*i +: 4] >= best)) begin
            any = 1'b1;
            win = i[4:0];
            best = lvl[4*i +: 4];
        end
    end
end

endmodule // ivpm_arbiter

// ==== design/ivpm_defs.vh ====
// Constants for the interrupt vector and priority resolver
`ifndef IVPM_DEFS_VH
`define IVPM_DEFS_VH

// Source count and source index positions
`define IVPM_NSRC 29
// Pin sources: external requests 0-11 and the non-maskable pin on top
`define IVPM_NPIN 13
`define IVPM_IDX_NMI 0
`define IVPM_IDX_SLEEP 1
`define IVPM_IDX_EXT0 2
`define IVPM_IDX_WDT 14
`define IVPM_IDX_ADC 15
`define IVPM_IDX_T0 16
`define IVPM_IDX_T1 21
`define IVPM_IDX_T2 25

// Vector numbers
`define IVPM_VEC_NMI 8'h07
`define IVPM_VEC_SLEEP 8'h12
`define IVPM_VEC_EXT0 8'h40
`define IVPM_VEC_WDT 8'h51
`define IVPM_VEC_ADC 8'h56
`define IVPM_VEC_T0 8'h58
`define IVPM_VEC_T1 8'h5D
`define IVPM_VEC_T2 8'h61

// Mode that enables programmed levels
`define IVPM_MODE_PRIO 2'h2
// Level above any programmable 3-bit level
`define IVPM_LVL_TOP 4'h8

// Register byte addresses (word index times four)
`define IVPM_ADDR_PRIO0 8'h00
`define IVPM_ADDR_PRIO1 8'h04
`define IVPM_ADDR_PRIO2 8'h08
`define IVPM_ADDR_PRIO3 8'h0C
`define IVPM_ADDR_PRIO4 8'h10
`define IVPM_ADDR_PRIO5 8'h14
`define IVPM_ADDR_PRIO6 8'h18
`define IVPM_ADDR_CTRL 8'h1C
`define IVPM_ADDR_PEND 8'h20
`define IVPM_ADDR_RESULT 8'h24

// Priority register reset value and field positions
`define IVPM_PRIO_RST 16'h7777
`define IVPM_FLD_HI 12
`define IVPM_FLD_MH 8
`define IVPM_FLD_ML 4
`define IVPM_FLD_LO 0

// Control register fields
`define IVPM_CTRL_MODE_LSB 0
`define IVPM_CTRL_RST 32'h00000000
`define IVPM_MODE_RST 2'h0

// Pending register error bits, write 1 to clear
`define IVPM_PEND_DTE_ERR 31
`define IVPM_PEND_BME_ERR 30

// Bus response codes
`define IVPM_RESP_OK 2'h0
`define IVPM_RESP_ERR 2'h2

`endif

// ==== design/ivpm_top.v ====
// Interrupt vector, offset and priority resolver with Avalon-MM registers
// How it works
// - By default the smaller vector number wins arbitration.
// - Programmed levels reorder sources only in control mode 2.
// - Equal programmed levels fall back to the default vector order.
// - Pin non-maskable request: vector 7, offset 1C, top rank, no engines.
// - Sleep request: vector 18, offset 48, no level field, no engines.
// - External request 0: vector 64, level register 0 bits 14:12, transfer engine only.
// - External requests 1-11: vectors 65-75, successive 3-bit fields, transfer engine only.
// - Reserved vectors 76-80, 82-85, 87 are never issued.
// - Watchdog overflow: vector 81, register 4 bits 10:8, no engines.
// - Conversion end: vector 86, register 5 bits 10:8, both engines.
// - Timer 0: vectors 88-92, register 5 bits 6:4; A both, B-D transfer.
// - Timer 1: vectors 93-96, register 5 bits 2:0; A both, B transfer.
// - Timer 2: vectors 97-100, register 6 bits 14:12; vector 100 ranks lowest among equal levels.
// - Non-maskable request ignores mode and masks, flags engine errors, stops block moves.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "ivpm_defs.vh"

module ivpm_top #(
    parameter NSRC = `IVPM_NSRC
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [1:0] avs_response,
    // Sources from pins (asynchronous)
    input wire nmi_pin_request,
    input wire [11:0] external_request,
    // Sources from on-chip logic (same clock)
    input wire sleep_request,
    input wire watchdog_overflow_request,
    input wire conversion_end_request,
    input wire [4:0] timer0_request,
    input wire [3:0] timer1_request,
    input wire [3:0] timer2_request,
    // CPU mask: in mode 2, maskable requests at or below this level are held off
    input wire [2:0] cpu_mask_level,
    // Resolved request toward the CPU
    output reg irq_valid_q,
    output reg [7:0] irq_vector_q,
    output reg [9:0] irq_offset_q,
    output reg [3:0] irq_level_q,
    output reg data_transfer_engine_ok_q,
    output reg block_move_engine_ok_q,
    // Error effects of the non-maskable request
    output reg data_transfer_engine_error_q,
    output reg block_move_engine_error_q,
    output reg block_move_engine_stop_q
);

// -----------------------------------------------------------------
// Helper functions
// -----------------------------------------------------------------
// Vector number of a source index
function [7:0] vec_of;
    input [4:0] idx;
    reg [31:0] t;
    begin
        t = 32'h00000000;
        if (idx == `IVPM_IDX_NMI)
            t = `IVPM_VEC_NMI;
        else if (idx == `IVPM_IDX_SLEEP)
            t = `IVPM_VEC_SLEEP;
        else if (idx < `IVPM_IDX_WDT)
            t = `IVPM_VEC_EXT0 + idx - `IVPM_IDX_EXT0;
        else if (idx == `IVPM_IDX_WDT)
            t = `IVPM_VEC_WDT;
        else if (idx == `IVPM_IDX_ADC)
            t = `IVPM_VEC_ADC;
        else if (idx < `IVPM_IDX_T1)
            t = `IVPM_VEC_T0 + idx - `IVPM_IDX_T0;
        else if (idx < `IVPM_IDX_T2)
            t = `IVPM_VEC_T1 + idx - `IVPM_IDX_T1;
        else
            t = `IVPM_VEC_T2 + idx - `IVPM_IDX_T2;
        // Vectors stay below 128, so the low byte is the whole value
        vec_of = t[7:0];
    end
endfunction

// Pick a 3-bit field from a 16-bit priority register by slot 0..3
function [2:0] fld;
    input [15:0] r;
    input [1:0] slot;
    begin
        case (slot)
            2'h0: fld = r[`IVPM_FLD_HI +: 3];
            2'h1: fld = r[`IVPM_FLD_MH +: 3];
            2'h2: fld = r[`IVPM_FLD_ML +: 3];
            default: fld = r[`IVPM_FLD_LO +: 3];
        endcase
    end
endfunction

// -----------------------------------------------------------------
// Input synchronisers for pin sources
// -----------------------------------------------------------------
wire [`IVPM_NPIN-1:0] pin_raw = {nmi_pin_request, external_request};
wire [`IVPM_NPIN-1:0] pin_sync;
wire nmi_sync = pin_sync[`IVPM_NPIN-1];
reg nmi_prev_q;
genvar g;

// Two flops per pin before any logic looks at it
generate
    for (g = 0; g < `IVPM_NPIN; g = g + 1) begin : g_pin
        reg meta_q;
        reg sync_q;
        always @(posedge clk) begin
            if (sys_rst) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= pin_raw[g];
                sync_q <= meta_q;
            end
        end
        assign pin_sync[g] = sync_q;
    end
endgenerate

// Previous synchronised level; resets to the idle low pin so no false edge
always @(posedge clk) begin
    if (sys_rst)
        nmi_prev_q <= 1'b0;
    else
        nmi_prev_q <= nmi_sync;
end

// Rising edge of the synchronised non-maskable pin
wire nmi_edge = nmi_sync & ~nmi_prev_q;

// -----------------------------------------------------------------
// Registers
// -----------------------------------------------------------------
reg [15:0] prio_q [0:6];
reg [1:0] mode_q;
reg nmi_pend_q;
reg ack_q;
integer r;

wire [5:0] word_idx = avs_address[7:2];
wire bus_req = avs_read | avs_write;
// A write lands only at the edge where waitrequest is seen low
wire bus_wr = avs_write & ~avs_read & ack_q;
wire prio_sel = avs_address < `IVPM_ADDR_CTRL;
wire ctrl_sel = avs_address == `IVPM_ADDR_CTRL;
wire pend_sel = avs_address == `IVPM_ADDR_PEND;
wire res_sel = avs_address == `IVPM_ADDR_RESULT;

// Priority level registers, two byte lanes each
always @(posedge clk) begin
    if (sys_rst) begin
        for (r = 0; r < 7; r = r + 1)
            prio_q[r] <= `IVPM_PRIO_RST;
    end else if (bus_wr && prio_sel) begin
        if (avs_byteenable[0])
            prio_q[word_idx[2:0]][7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
            prio_q[word_idx[2:0]][15:8] <= avs_writedata[15:8];
    end
end

// Interrupt control mode
always @(posedge clk) begin
    if (sys_rst)
        mode_q <= `IVPM_MODE_RST;
    else if (bus_wr && ctrl_sel && avs_byteenable[0])
        mode_q <= avs_writedata[`IVPM_CTRL_MODE_LSB +: 2];
end

// Sticky engine error flags; software writes 1 to clear, a same-cycle edge wins
always @(posedge clk) begin
    if (sys_rst) begin
        data_transfer_engine_error_q <= 1'b0;
        block_move_engine_error_q <= 1'b0;
    end else if (nmi_edge) begin
        data_transfer_engine_error_q <= 1'b1;
        block_move_engine_error_q <= 1'b1;
    end else if (bus_wr && pend_sel && avs_byteenable[3]) begin
        if (avs_writedata[`IVPM_PEND_DTE_ERR])
            data_transfer_engine_error_q <= 1'b0;
        if (avs_writedata[`IVPM_PEND_BME_ERR])
            block_move_engine_error_q <= 1'b0;
    end
end

// One-cycle stop pulse to every block move channel
always @(posedge clk) begin
    if (sys_rst)
        block_move_engine_stop_q <= 1'b0;
    else
        block_move_engine_stop_q <= nmi_edge;
end

// Latched non-maskable request, held until shown to the CPU; a new edge wins
always @(posedge clk) begin
    if (sys_rst)
        nmi_pend_q <= 1'b0;
    else if (nmi_edge)
        nmi_pend_q <= 1'b1;
    else if (irq_valid_q && irq_vector_q == `IVPM_VEC_NMI)
        nmi_pend_q <= 1'b0;
end

// -----------------------------------------------------------------
// Source vector, levels and engine permissions
// -----------------------------------------------------------------
wire [NSRC-1:0] req = {timer2_request, timer1_request, timer0_request, conversion_end_request,
                       watchdog_overflow_request, pin_sync[`IVPM_NPIN-2:0], sleep_request, nmi_pend_q};

// Transfer engine may be triggered: external, conversion end, timer A/B(/C/D)
wire [NSRC-1:0] dte_ok = {2'b00, 2'b11, 2'b00, 2'b11, 1'b0, 4'hF, 1'b1, 1'b0, 12'hFFF, 2'b00};
// Block move engine may be triggered: conversion end and each timer A
wire [NSRC-1:0] bme_ok = {3'b000, 1'b1, 3'b000, 1'b1, 4'h0, 1'b1, 1'b1, 1'b0, 12'h000, 2'b00};

reg [4*NSRC-1:0] lvl;
reg [NSRC-1:0] eligible;
integer s;

// Effective level per source; flat levels outside mode 2
always @* begin
    lvl = {4*NSRC{1'b0}};
    eligible = req;
    if (mode_q == `IVPM_MODE_PRIO) begin
        for (s = 0; s < 12; s = s + 1)
            lvl[4*(`IVPM_IDX_EXT0+s) +: 4] = {1'b0, fld(prio_q[s/4], s[1:0])};
        lvl[4*`IVPM_IDX_WDT +: 4] = {1'b0, fld(prio_q[4], 2'h1)};
        lvl[4*`IVPM_IDX_ADC +: 4] = {1'b0, fld(prio_q[5], 2'h1)};
        for (s = 0; s < 5; s = s + 1)
            lvl[4*(`IVPM_IDX_T0+s) +: 4] = {1'b0, fld(prio_q[5], 2'h2)};
        for (s = 0; s < 4; s = s + 1)
            lvl[4*(`IVPM_IDX_T1+s) +: 4] = {1'b0, fld(prio_q[5], 2'h3)};
        for (s = 0; s < 4; s = s + 1)
            lvl[4*(`IVPM_IDX_T2+s) +: 4] = {1'b0, fld(prio_q[6], 2'h0)};
        // Maskable sources at or below the CPU mask level wait
        for (s = `IVPM_IDX_EXT0; s < NSRC; s = s + 1)
            if (lvl[4*s +: 4] <= {1'b0, cpu_mask_level})
                eligible[s] = 1'b0;
    end
    // Non-maskable and sleep sources always rank above everything
    lvl[4*`IVPM_IDX_NMI +: 4] = `IVPM_LVL_TOP;
    lvl[4*`IVPM_IDX_SLEEP +: 4] = `IVPM_LVL_TOP;
end

wire any;
wire [4:0] win;

ivpm_arbiter #(
    .NSRC(NSRC)
) u_arb (
    .req(eligible),
    .lvl(lvl),
    .any(any),
    .win(win)
);

// -----------------------------------------------------------------
// Registered result toward the CPU
// -----------------------------------------------------------------
wire [7:0] win_vec = vec_of(win);

// Result is updated every cycle from the current winner
always @(posedge clk) begin
    if (sys_rst) begin
        irq_valid_q <= 1'b0;
        irq_vector_q <= 8'h00;
        irq_offset_q <= 10'h000;
        irq_level_q <= 4'h0;
        data_transfer_engine_ok_q <= 1'b0;
        block_move_engine_ok_q <= 1'b0;
    end else begin
        irq_valid_q <= any;
        irq_vector_q <= any ? win_vec : 8'h00;
        irq_offset_q <= any ? {win_vec, 2'b00} : 10'h000;
        irq_level_q <= any ? lvl[4*win +: 4] : 4'h0;
        data_transfer_engine_ok_q <= any & dte_ok[win];
        block_move_engine_ok_q <= any & bme_ok[win];
    end
end

// -----------------------------------------------------------------
// Bus read path
// -----------------------------------------------------------------
reg [31:0] rdata_d;
reg [1:0] resp_d;
reg hit_d;

// Read decode; unmapped addresses read zero with a slave error
always @* begin
    rdata_d = 32'h00000000;
    resp_d = `IVPM_RESP_OK;
    hit_d = 1'b1;
    if (prio_sel)
        rdata_d = {16'h0000, prio_q[word_idx[2:0]]};
    else if (ctrl_sel)
        rdata_d = {30'h00000000, mode_q};
    else if (pend_sel)
        rdata_d = {data_transfer_engine_error_q, block_move_engine_error_q, {(30-NSRC){1'b0}}, req};
    else if (res_sel)
        rdata_d = {8'h00, block_move_engine_ok_q, data_transfer_engine_ok_q,
                   irq_valid_q, irq_level_q[2:0], irq_offset_q, irq_vector_q};
    else
        hit_d = 1'b0;
    if (!hit_d)
        resp_d = `IVPM_RESP_ERR;
end

// Every access gets one wait state so that read data and response leave flops
assign avs_waitrequest = bus_req & ~ack_q;

// Capture the answer in the waited cycle; it stands while waitrequest is low
always @(posedge clk) begin
    if (sys_rst) begin
        ack_q <= 1'b0;
        avs_readdata <= 32'h00000000;
        avs_response <= `IVPM_RESP_OK;
    end else begin
        ack_q <= avs_waitrequest;
        if (avs_waitrequest) begin
            avs_readdata <= avs_read ? rdata_d : 32'h00000000;
            avs_response <= resp_d;
        end
    end
end

endmodule // ivpm_top
